// *** pss_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pss_ctrl_model
  import pss_pkg::*;
(
  input  wire logic                       sys_clk,  // Clock
  input  wire logic                       cmdWrite, // Write on pins
  input  wire logic [pss_pkg::DATA_W-1:0] cmdData,  // Its data
  input  wire logic                       dataOe,   // Memory drives
  input  wire logic [pss_pkg::DATA_W-1:0] dataOut,  // Memory value
  output var  logic [pss_pkg::DATA_W-1:0] busLevel  // Resolved bus
);
  logic [2:0]        wrPipe_q;
  logic [DATA_W-1:0] dPipe_q [3];
  logic [DATA_W-1:0] last_q;
  // Write data rides a delay line to the slot of its command
  always_ff @(posedge sys_clk) begin
    wrPipe_q <= {wrPipe_q[1:0], cmdWrite};
    dPipe_q <= '{cmdData, dPipe_q[0], dPipe_q[1]};
    last_q <= busLevel;
  end
  // Contention shows as unknown, a released bus drifts away
  always_comb begin
    if (dataOe && wrPipe_q[2]) busLevel = 'x;
    else if (dataOe) busLevel = dataOut;
    else if (wrPipe_q[2]) busLevel = dPipe_q[2];
    else busLevel = ~last_q;
  end
endmodule : pss_ctrl_model
`default_nettype wire

// *** pss_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module pss_fifo #(
  parameter int unsigned WIDTH = 36,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             sys_clk,   // Clock
  input  wire logic             nrst,      // Sync reset, active low
  input  wire logic             inValid,   // Write request
  output var  logic             inReady,   // Room available
  input  wire logic [WIDTH-1:0] inData,    // Write word
  output var  logic             outValid,  // Word available
  input  wire logic             outReady,  // Drain request
  output var  logic [WIDTH-1:0] outData    // Head word
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  wire              doPush = inValid && inReady;
  wire              doPop  = outValid && outReady;

  // Honest flags from the occupancy count
  assign inReady  = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];

  // ---------------------------------------------------------------
  // Storage and pointers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (doPush) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doPush) wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      if (doPop)  rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      count_q <= count_q + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule : pss_fifo
`default_nettype wire

// *** pss_pkg.sv ***
package pss_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W     = 36;        // Wide variant word width
  localparam int unsigned LANES      = 4;         // Byte lanes of the wide variant
  localparam int unsigned LANE_W     = DATA_W / LANES;
  localparam int unsigned ADDR_W     = 10;        // Modelled array depth, address bits
  localparam int unsigned BURST_W    = 2;         // Burst counter width
  localparam int unsigned FIFO_DEPTH = 32;        // Read return buffer depth

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ    = 125;
  localparam int unsigned PIPE_DLY   = 2;         // Active edges from command to data

  // ---------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
  localparam logic [LANES-1:0]   LANES_OFF  = 4'hF;
  localparam logic               ORDER_LINEAR = 1'b0;

  typedef enum logic [1:0] {
    PSS_IDLE  = 2'b00,
    PSS_READ  = 2'b01,
    PSS_WRITE = 2'b10
  } pss_op_e;

  typedef struct packed {
    pss_op_e                 op;
    logic [ADDR_W-1:0]       addr;
    logic [LANES-1:0]        laneN;
  } pss_cmd_s;

endpackage : pss_pkg

// *** pss_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module pss_port
  import pss_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic                      sys_clk,               // Clock
  input  wire logic                      nrst,                  // Sync reset, low
  input  wire logic                      clock_qualifier_n,     // Stall when high
  input  wire logic                      chip_select_one_n,     // Select, low
  input  wire logic                      chip_select_two,       // Select, high
  input  wire logic                      chip_select_three_n,   // Select, low
  input  wire logic                      writeEnableN,          // Write when low
  input  wire logic [pss_pkg::LANES-1:0] byte_lane_select_n,    // Lane writes, low
  input  wire logic                      burst_advance_or_load, // High advances burst
  input  wire logic [pss_pkg::ADDR_W-1:0] addrIn,               // Word address
  input  wire logic                      burstOrder,            // 1 interleaved
  input  wire logic                      outputEnableN,         // Driver gate, low
  input  wire logic                      sleep_request,         // Sleep, high
  input  wire logic [pss_pkg::DATA_W-1:0] dataIn,               // Bus level in
  output var  logic [pss_pkg::DATA_W-1:0] dataOut,              // Bus drive value
  output var  logic                      dataOe,                // Bus drive enable
  output var  logic                      asleep,                // Sleep status
  output var  logic [pss_pkg::DATA_W-1:0] readStream,           // Returned read word
  output var  logic                      readStreamValid,       // Read word valid
  input  wire logic                      readStreamReady        // Consumer ready
);
  import pss_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic qualS1_q, qualS2_q, sleepS1_q, sleepS2_q, oeS1_q, oeS2_q;

  // Async pins pass two flops before use
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      qualS1_q  <= 1'b1;
      qualS2_q  <= 1'b1;
      sleepS1_q <= 1'b0;
      sleepS2_q <= 1'b0;
      oeS1_q    <= 1'b1;
      oeS2_q    <= 1'b1;
    end else begin
      qualS1_q  <= clock_qualifier_n;
      qualS2_q  <= qualS1_q;
      sleepS1_q <= sleep_request;
      sleepS2_q <= sleepS1_q;
      oeS1_q    <= outputEnableN;
      oeS2_q    <= oeS1_q;
    end
  end

  // ---------------------------------------------------------------
  // Input registers
  // ---------------------------------------------------------------
  logic                  ceN_q, ce2_q, ce3N_q, weN_q, advLd_q;
  logic [LANES-1:0]      laneN_q;
  logic [ADDR_W-1:0]     addr_q;
  logic [DATA_W-1:0]     din_q;

  // Every synchronous pin except burstOrder captured on the rising edge
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ceN_q   <= 1'b1;
      ce2_q   <= 1'b0;
      ce3N_q  <= 1'b1;
      weN_q   <= 1'b1;
      advLd_q <= 1'b0;
      laneN_q <= LANES_OFF;
      addr_q  <= '0;
      din_q   <= '0;
    end else begin
      ceN_q   <= chip_select_one_n;
      ce2_q   <= chip_select_two;
      ce3N_q  <= chip_select_three_n;
      weN_q   <= writeEnableN;
      advLd_q <= burst_advance_or_load;
      laneN_q <= byte_lane_select_n;
      addr_q  <= addrIn;
      din_q   <= dataIn;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic                  fifoReady;
  wire  run      = !qualS2_q && fifoReady;
  wire  selected = !ceN_q && ce2_q && !ce3N_q;
  wire  sleeping = sleepS2_q;

  // Burst counter and address sequencing
  logic [ADDR_W-1:0]     base_q;
  logic [BURST_W-1:0]    cnt_q;
  logic                  lastWrite_q;
  logic                  lastValid_q;
  wire  [BURST_W-1:0]    cntNext = cnt_q + BURST_ONE;
  wire  [BURST_W-1:0]    lowLin  = base_q[BURST_W-1:0] + cntNext;
  wire  [BURST_W-1:0]    lowInt  = base_q[BURST_W-1:0] ^ cntNext;
  wire  [BURST_W-1:0]    lowSel  = (burstOrder == ORDER_LINEAR) ? lowLin : lowInt;
  wire                   isAdv   = advLd_q && lastValid_q;
  wire  [ADDR_W-1:0]     cmdAddr = isAdv ? {base_q[ADDR_W-1:BURST_W], lowSel} : addr_q;
  wire                   cmdVal  = !sleeping && (isAdv || (!advLd_q && selected));
  wire                   cmdWr   = isAdv ? lastWrite_q : !weN_q;
  wire  pss_op_e         cmdOp   = !cmdVal ? PSS_IDLE : (cmdWr ? PSS_WRITE : PSS_READ);

  // Burst state updates only on active edges
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      base_q      <= '0;
      cnt_q       <= BURST_ZERO;
      lastWrite_q <= 1'b0;
      lastValid_q <= 1'b0;
    end else if (run) begin
      if (cmdVal && !isAdv) begin
        base_q      <= addr_q;
        cnt_q       <= BURST_ZERO;
        lastWrite_q <= !weN_q;
      end else if (isAdv) begin
        cnt_q       <= cntNext;
      end
      lastValid_q <= cmdVal;
    end
  end

  // ---------------------------------------------------------------
  // Command pipeline, two active edges deep
  // ---------------------------------------------------------------
  pss_cmd_s              pipe_q [PIPE_DLY];
  pss_cmd_s              cmdNow;
  assign cmdNow = '{op: cmdOp, addr: cmdAddr, laneN: laneN_q};

  // Each stage advances back to back, no bubbles
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      for (int i = 0; i < PIPE_DLY; i++) begin
        pipe_q[i] <= '{op: PSS_IDLE, addr: '0, laneN: LANES_OFF};
      end
    end else if (run) begin
      pipe_q[0] <= cmdNow;
      for (int i = 1; i < PIPE_DLY; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  // ---------------------------------------------------------------
  // Array and self-timed lane writes
  // ---------------------------------------------------------------
  localparam int unsigned WORDS = 1 << ADDR_W;
  logic [DATA_W-1:0]     array_q [WORDS];
  pss_cmd_s              late;
  assign late = pipe_q[PIPE_DLY-1];
  wire  isLateWr = (late.op == PSS_WRITE);

  // Write waits one edge so its bus word has reached the data register
  logic                  wrPend_q;
  logic [ADDR_W-1:0]     wrAddr_q;
  logic [LANES-1:0]      wrLanes_q;

  // Pending write slot, captured as the bus word is sampled
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wrPend_q  <= 1'b0;
      wrAddr_q  <= '0;
      wrLanes_q <= LANES_OFF;
    end else if (run) begin
      wrPend_q  <= isLateWr;
      wrAddr_q  <= late.addr;
      wrLanes_q <= late.laneN;
    end
  end

  // Lane writes from the bus register, no strobe needed
  always_ff @(posedge sys_clk) begin
    if (run && wrPend_q) begin
      for (int l = 0; l < LANES; l++) begin
        if (!wrLanes_q[l]) begin
          array_q[wrAddr_q][l*LANE_W +: LANE_W] <= din_q[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Output registers and driver control
  // ---------------------------------------------------------------
  pss_cmd_s              mid;
  logic [DATA_W-1:0]     arrWord;
  wire  [DATA_W-1:0]     rdWord;
  assign mid     = pipe_q[PIPE_DLY-2];
  assign arrWord = array_q[mid.addr];
  wire  midRd    = (mid.op == PSS_READ);
  wire  driveNxt = midRd && !oeS2_q;
  wire  hitLate  = isLateWr && (late.addr == mid.addr);
  wire  hitPend  = wrPend_q && (wrAddr_q == mid.addr);
  wire  pushRd   = run && midRd;

  // Writes not yet in the array forward their lanes, newest first;
  // the write one slot ahead still has its word only on the bus pins
  for (genvar l = 0; l < LANES; l++) begin : g_fwd
    wire useLate = hitLate && !late.laneN[l];
    wire usePend = hitPend && !wrLanes_q[l];
    assign rdWord[l*LANE_W +: LANE_W] = useLate ? dataIn[l*LANE_W +: LANE_W]
                                      : usePend ? din_q[l*LANE_W +: LANE_W]
                                      : arrWord[l*LANE_W +: LANE_W];
  end

  // Read word launched from a register, drivers follow the pipe
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dataOut <= '0;
      dataOe  <= 1'b0;
      asleep  <= 1'b0;
    end else begin
      asleep <= sleeping;
      if (run) begin
        if (midRd) begin
          dataOut <= rdWord;
        end
        dataOe <= driveNxt;
      end else if (oeS2_q) begin
        dataOe <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read return stream through buffer
  // ---------------------------------------------------------------
  logic [DATA_W-1:0]     fifoData;
  logic                  fifoValid;

  // Push rides the launch edge; run already needs room, so none is lost

  pss_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .inValid  (pushRd),
    .inReady  (fifoReady),
    .inData   (rdWord),
    .outValid (fifoValid),
    .outReady (readStreamReady && !readStreamValid),
    .outData  (fifoData)
  );

  // Output stage register for the stream
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      readStreamValid <= 1'b0;
      readStream      <= '0;
    end else if (readStreamValid) begin
      if (readStreamReady) readStreamValid <= 1'b0;
    end else if (fifoValid && readStreamReady) begin
      readStreamValid <= 1'b1;
      readStream      <= fifoData;
    end
  end

endmodule : pss_port
`default_nettype wire

// *** pss_port_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module pss_port_monitor
  import pss_pkg::*;
(
  input wire logic                       sys_clk,             // Clock
  input wire logic                       nrst,                // Reset
  input wire logic                       clock_qualifier_n,   // Stall
  input wire logic                       chip_select_one_n,   // Select
  input wire logic                       chip_select_two,     // Select
  input wire logic                       chip_select_three_n, // Select
  input wire logic                       writeEnableN,        // Write
  input wire logic                       outputEnableN,       // Gate
  input wire logic                       sleep_request,       // Sleep
  input wire logic [pss_pkg::DATA_W-1:0] dataOut,             // Drive value
  input wire logic                       dataOe,              // Drive enable
  input wire logic                       asleep,              // Sleep status
  input wire logic [pss_pkg::DATA_W-1:0] readStream,          // Stream word
  input wire logic                       readStreamValid,     // Stream valid
  input wire logic                       readStreamReady      // Stream ready
);
  // ---------------------------------------------------------------
  // Port timing checks
  // ---------------------------------------------------------------
  logic sel, run, rdOk;
  // Selection and quiet-pipeline conditions
  assign sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
  assign run = !clock_qualifier_n && !asleep && !sleep_request;
  assign rdOk = run && !outputEnableN;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_rst_quiet; disable iff (1'b0) !nrst |=> !dataOe && !readStreamValid; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("Outputs live in reset");
  property p_wr_hiz; run[*4] ##0 (sel && !writeEnableN) ##1 run[*3] |-> !dataOe; endproperty
  a_wr_hiz: assert property (p_wr_hiz) else $error("Driving in write slot");
  property p_rd_drive; rdOk[*4] ##0 (sel && writeEnableN) ##1 rdOk[*3] |-> dataOe; endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("Read slot not driven");
  property p_unsel; (!sel && run)[*8] |-> !dataOe; endproperty
  a_unsel: assert property (p_unsel) else $error("Driving while unselected");
  property p_oe_gate; outputEnableN[*5] |-> !dataOe; endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("Driving with gate off");
  property p_sleep_on; sleep_request[*5] |-> asleep; endproperty
  a_sleep_on: assert property (p_sleep_on) else $error("Sleep not entered");
  property p_sleep_off; !sleep_request[*5] |-> !asleep; endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("Sleep not left");
  property p_stall; clock_qualifier_n[*5] |=> $stable(dataOut) && $stable(dataOe); endproperty
  a_stall: assert property (p_stall) else $error("Outputs moved in stall");
  property p_hold; readStreamValid && !readStreamReady |=> readStreamValid && $stable(readStream);
  endproperty
  a_hold: assert property (p_hold) else $error("Stream word dropped");
endmodule : pss_port_monitor
`default_nettype wire

// *** test_pipelined_sync_sram_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_pipelined_sync_sram_port;
  import pss_pkg::*;
  // ---------------------------------------------------------------
  // Bench state and model
  // ---------------------------------------------------------------
  logic              sys_clk, nrst, qualN, cs1N, cs2, cs3N, weN, oeN, sleepReq, rdy, holdRdy;
  logic              dataOe, asleep, rsValid, cmdWrite, burstAdv, burstOrd;
  logic [LANES-1:0]  lanesN;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] busLevel, dataOut, rs, cmdData;
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] expQ [$];
  logic [31:0]       rnd, rdyRnd;
  int                bad_count, n_checks;

  pss_port i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .clock_qualifier_n(qualN), .chip_select_one_n(cs1N),
    .chip_select_two(cs2), .chip_select_three_n(cs3N), .writeEnableN(weN),
    .byte_lane_select_n(lanesN), .burst_advance_or_load(burstAdv), .addrIn(addr),
    .burstOrder(burstOrd), .outputEnableN(oeN), .sleep_request(sleepReq), .dataIn(busLevel),
    .dataOut(dataOut), .dataOe(dataOe), .asleep(asleep), .readStream(rs),
    .readStreamValid(rsValid), .readStreamReady(rdy));
  pss_ctrl_model i_ctrl (.sys_clk(sys_clk), .cmdWrite(cmdWrite), .cmdData(cmdData),
    .dataOe(dataOe), .dataOut(dataOut), .busLevel(busLevel));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One command cycle; model memory and expected reads follow it
  task automatic cmd(input logic wr, input logic [3:0] a, input logic [LANES-1:0] ln,
                     input logic [2:0] off);
    logic [DATA_W-1:0] d;
    rnd = lfsr(rnd);
    d = {rnd[3:0], rnd};
    {cs1N, cs2, cs3N, weN, cmdWrite} <= {off[0], !off[1], off[2], !wr, wr};
    {lanesN, addr, cmdData} <= {ln, 6'h00, a, d};
    for (int l = 0; l < LANES; l++)
      if (wr && off == 3'h0 && !ln[l]) mem[a][l*LANE_W +: LANE_W] = d[l*LANE_W +: LANE_W];
    if (!wr && off == 3'h0) expQ.push_back(mem[a]);
    @(posedge sys_clk);
  endtask : cmd

  // Load then three advances; low address bits count or flip
  task automatic burst(input logic wr, input logic [3:0] a);
    cmd(wr, a, {LANES{!wr}}, 3'h0);
    burstAdv <= 1'b1;
    for (int k = 1; k < 4; k++)
      cmd(wr, {a[3:2], burstOrd ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)}, {LANES{!wr}}, 3'h0);
    burstAdv <= 1'b0;
  endtask : burst

  task automatic idle(input int n);
    {cs1N, cmdWrite} <= 2'h2;
    repeat (n) @(posedge sys_clk);
  endtask : idle

  task automatic results();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Consumer with random back-pressure compares every word taken
  always @(posedge sys_clk) begin
    rdyRnd <= lfsr(rdyRnd);
    rdy <= !holdRdy && rdyRnd[7];
    if (nrst && rsValid && rdy) check(rs, expQ.pop_front());
  end

  initial begin
    #40000;
    bad_count++;
    results();
  end

  initial begin
    {nrst, qualN, cs1N, cs2, cs3N, weN, oeN, sleepReq, holdRdy, cmdWrite} = 10'h090;
    {burstAdv, burstOrd, lanesN, addr, cmdData} = '0;
    rnd = 32'h3366BFCD;
    rdyRnd = 32'h3366BFCD;
    bad_count = 0;
    n_checks = 0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    idle(3);
    for (int i = 0; i < 16; i++) cmd(1'b1, 4'(i), 4'h0, 3'h0);
    for (int i = 0; i < 48; i++) cmd(rnd[0], rnd[7:4], rnd[11:8], 3'h0);
    $display("test mixed traffic done");
    for (int k = 0; k < 3; k++) cmd(1'b1, 4'h3, 4'h0, 3'(1 << k));
    cmd(1'b0, 4'h3, 4'hF, 3'h0);
    $display("test chip selects done");
    burst(1'b1, 4'h6);
    burst(1'b0, 4'h6);
    idle(2);
    burstOrd <= 1'b1;
    idle(2);
    burst(1'b1, 4'h9);
    burst(1'b0, 4'h9);
    $display("test burst order done");
    cmd(1'b0, 4'h5, 4'hF, 3'h0);
    qualN <= 1'b1;
    idle(8);
    qualN <= 1'b0;
    idle(8);
    $display("test stall done");
    {sleepReq, oeN} <= 2'h3;
    idle(10);
    {sleepReq, oeN} <= 2'h0;
    idle(8);
    for (int i = 0; i < 4; i++) cmd(1'b0, 4'(i), 4'hF, 3'h0);
    $display("test sleep done");
    idle(2);
    for (int t = 0; t < 200 && expQ.size() != 0; t++) @(posedge sys_clk);
    holdRdy <= 1'b1;
    idle(2);
    for (int i = 0; i < 31; i++) cmd(1'b0, rnd[3:0], 4'hF, 3'h0);
    idle(20);
    holdRdy <= 1'b0;
    for (int t = 0; t < 3000 && expQ.size() != 0; t++) @(posedge sys_clk);
    check(DATA_W'(expQ.size()), '0);
    $display("test fill and drain done");
    results();
  end
endmodule : test_pipelined_sync_sram_port

bind pss_port pss_port_monitor i_mon (
  .sys_clk(sys_clk), .nrst(nrst), .clock_qualifier_n(clock_qualifier_n),
  .chip_select_one_n(chip_select_one_n), .chip_select_two(chip_select_two),
  .chip_select_three_n(chip_select_three_n), .writeEnableN(writeEnableN),
  .outputEnableN(outputEnableN), .sleep_request(sleep_request), .dataOut(dataOut),
  .dataOe(dataOe), .asleep(asleep), .readStream(readStream),
  .readStreamValid(readStreamValid), .readStreamReady(readStreamReady));
`default_nettype wire
